// ### design/rv32i_integer_execute.sv
// Purpose: Single-cycle RV32I integer execute for arithmetic, logic, shifts, upper
//          immediates and the two unconditional jumps
// Assumes: Register file reads stand on the issue bus; results retire next cycle
// Notes: No back-pressure; one instruction may be issued every cycle
//
// Contract
// - Index zero reads zero; results aimed at index zero are dropped.
// - Registers, pc and every result are 32 bits wide.
// - Accept 4-byte and 2-byte instructions; sequential pc steps by 4 or 2.
// - Single thread; data misalignment never rejected here.
// - Add-immediate sums rs1 with the sign-extended 12-bit immediate.
// - AND/OR/XOR immediate use the sign-extended 12-bit immediate.
// - Signed immediate compare writes 1 when rs1 is less, else 0.
// - Unsigned immediate compare sign-extends first, compares unsigned.
// - Immediate shifts take amount from low five immediate bits.
// - Logical shifts fill vacated bits with zeros.
// - Arithmetic right shifts copy original sign into vacated bits.
// - Upper immediate load puts 20 bits high, low 12 bits zero.
// - Upper immediate to pc adds shifted immediate to current pc.
// - Register add sums sources; subtract gives rs1 minus rs2.
// - Register AND/OR/XOR combine both sources bitwise.
// - Register compare writes 1 when rs1 below rs2, signed or unsigned.
// - Jump-and-link targets pc plus offset, links the next instruction address.
// - Register jump target is rs1 plus immediate with bit zero cleared.
// - Register jump reads source and link before any write.
// - Taken jump to odd address raises misaligned exception.

module rv32i_integer_execute
	import rv32i_exec_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Decoded instruction from issue
	input wire issue_t issue_i,
	// Retired result to register file and fetch
	output result_t result_o
);

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic logic uses_rs2(input alu_op_t op);
		unique case (op)
			OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR,
			OP_SLT, OP_SLTU, OP_SLL, OP_SRL, OP_SRA: uses_rs2 = 1'b1;
			default: uses_rs2 = 1'b0;
		endcase
	endfunction

	function automatic logic is_jump(input alu_op_t op);
		is_jump = (op == OP_JAL) || (op == OP_JALR);
	endfunction

	function automatic logic [XLEN-1:0] read_reg(input logic [IDX_W-1:0] idx,
		input logic [XLEN-1:0] val);
		read_reg = (idx == ZERO_IDX) ? WORD_ZERO : val;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	exec_state_t st;
	exec_state_t next_st;

	logic [XLEN-1:0] src_a;
	logic [XLEN-1:0] src_b;
	logic [XLEN-1:0] imm_s12;
	logic [XLEN-1:0] imm_upper;
	logic [XLEN-1:0] jal_off;
	logic [XLEN-1:0] operand_b;
	logic [XLEN-1:0] seq_pc;
	logic [XLEN-1:0] shift_out;
	logic [SHAMT_W-1:0] shamt;
	logic shift_right;
	logic shift_arith;

	// ----------------------------------------------------------------
	// Operand preparation
	// ----------------------------------------------------------------
	// Both sources are sampled here, so a link into rs1 cannot corrupt the target
	assign src_a = read_reg(issue_i.rs1_idx, issue_i.rs1_val);
	assign src_b = read_reg(issue_i.rs2_idx, issue_i.rs2_val);
	assign imm_s12 = {{(XLEN-IMM12_W){issue_i.imm[IMM12_W-1]}},
		issue_i.imm[IMM12_W-1:0]};
	assign imm_upper = {issue_i.imm, {UPPER_LSB{1'b0}}};
	assign jal_off = {{(XLEN-IMM_W-1){issue_i.imm[IMM_W-1]}}, issue_i.imm, 1'b0};
	assign operand_b = uses_rs2(issue_i.op) ? src_b : imm_s12;
	// Compressed instructions advance by a halfword
	assign seq_pc = issue_i.pc + (issue_i.compressed ? HALF_STEP : FULL_STEP);

	// Upper bits of rs2 are ignored as a shift amount
	assign shamt = uses_rs2(issue_i.op) ? src_b[SHAMT_W-1:0] :
		issue_i.imm[SHAMT_W-1:0];
	assign shift_right = (issue_i.op == OP_SRLI) || (issue_i.op == OP_SRAI) ||
		(issue_i.op == OP_SRL) || (issue_i.op == OP_SRA);
	assign shift_arith = (issue_i.op == OP_SRAI) || (issue_i.op == OP_SRA);

	rv32i_shifter #(
		.WIDTH(XLEN),
		.AMT_W(SHAMT_W)
	) u_shifter (
		.data_i(src_a),
		.shamt_i(shamt),
		.right_i(shift_right),
		.arith_i(shift_arith),
		.data_o(shift_out)
	);

	// ----------------------------------------------------------------
	// Execute
	// ----------------------------------------------------------------
	always_comb begin
		logic [XLEN-1:0] value;
		logic [XLEN-1:0] target;
		logic bad_align;
		value = WORD_ZERO;
		target = seq_pc;
		bad_align = 1'b0;
		next_st = st;
		// All arithmetic is modulo 2^32; there is no overflow trap
		unique case (issue_i.op)
			OP_ADDI, OP_ADD: value = src_a + operand_b;
			OP_SUB: value = src_a - src_b;
			OP_ANDI, OP_AND: value = src_a & operand_b;
			OP_ORI, OP_OR: value = src_a | operand_b;
			OP_XORI, OP_XOR: value = src_a ^ operand_b;
			OP_SLTI, OP_SLT: begin
				value = ($signed(src_a) < $signed(operand_b)) ? WORD_ONE : WORD_ZERO;
			end
			OP_SLTIU, OP_SLTU: begin
				value = (src_a < operand_b) ? WORD_ONE : WORD_ZERO;
			end
			OP_SLLI, OP_SRLI, OP_SRAI, OP_SLL, OP_SRL, OP_SRA: value = shift_out;
			OP_LUI: value = imm_upper;
			OP_AUIPC: value = issue_i.pc + imm_upper;
			OP_JAL: begin
				value = seq_pc;
				target = issue_i.pc + jal_off;
			end
			OP_JALR: begin
				value = seq_pc;
				target = (src_a + imm_s12) & LSB_CLEAR;
			end
			default: value = WORD_ZERO;
		endcase
		// Only instruction targets are checked; data addresses never fault here
		bad_align = is_jump(issue_i.op) && target[0];
		next_st.op = issue_i.op;
		next_st.res.valid = issue_i.valid;
		next_st.res.rd_idx = issue_i.rd_idx;
		next_st.res.wr_data = value;
		next_st.res.target = target;
		next_st.res.misaligned = issue_i.valid && bad_align;
		// A faulting jump neither writes its link nor redirects fetch
		next_st.res.wr_en = issue_i.valid && !bad_align &&
			(issue_i.rd_idx != ZERO_IDX);
		next_st.res.jump = issue_i.valid && is_jump(issue_i.op) && !bad_align;
		next_st.res.next_pc = bad_align ? issue_i.pc : target;
		if (!issue_i.valid) begin
			next_st.res.wr_data = WORD_ZERO;
			next_st.res.target = WORD_ZERO;
			next_st.res.next_pc = WORD_ZERO;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign result_o = st.res;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_zero_dest: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.res.rd_idx == ZERO_IDX) |-> !st.res.wr_en)
		else $error("write to index zero not dropped");

	chk_result_timing: assert property (@(posedge clk_i) disable iff (srst_i)
		issue_i.valid |=> st.res.valid && (st.res.rd_idx == $past(issue_i.rd_idx)))
		else $error("result not one cycle after issue");

	chk_seq_step: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && !is_jump(st.op) |-> st.res.next_pc ==
		$past(issue_i.pc) + ($past(issue_i.compressed) ? HALF_STEP : FULL_STEP))
		else $error("sequential pc step wrong");

	chk_upper_zero: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_LUI) |->
		st.res.wr_data == {$past(issue_i.imm), {UPPER_LSB{1'b0}}})
		else $error("upper immediate load wrong");

	chk_sub_diff: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_SUB) && ($past(issue_i.rs1_idx) != ZERO_IDX) &&
		($past(issue_i.rs2_idx) != ZERO_IDX) |->
		st.res.wr_data == $past(issue_i.rs1_val) - $past(issue_i.rs2_val))
		else $error("subtract result wrong");

	chk_compare_bool: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op inside {OP_SLT, OP_SLTU, OP_SLTI, OP_SLTIU}) |->
		st.res.wr_data[XLEN-1:1] == '0)
		else $error("compare result not boolean");

	chk_sra_sign: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_SRAI) && ($past(issue_i.rs1_idx) != ZERO_IDX) |->
		st.res.wr_data[XLEN-1] == $past(issue_i.rs1_val[XLEN-1]))
		else $error("arithmetic shift lost sign");

	chk_link_value: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.wr_en && is_jump(st.op) |-> st.res.wr_data ==
		$past(issue_i.pc) + ($past(issue_i.compressed) ? HALF_STEP : FULL_STEP))
		else $error("link address wrong");

	chk_jalr_lsb: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_JALR) |-> !st.res.target[0] && !st.res.misaligned)
		else $error("register jump target lsb set");

	chk_misalign_flag: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && is_jump(st.op) |->
		(st.res.misaligned == st.res.target[0]) && (st.res.jump == !st.res.target[0]))
		else $error("misaligned jump handling wrong");

	// ----------------------------------------------------------------
	// Reference checks
	// ----------------------------------------------------------------
	// Operands rebuilt apart from the datapath so a shared slip cannot hide
	logic [XLEN-1:0] ref_a;
	logic [XLEN-1:0] ref_b;
	logic [XLEN-1:0] ref_i;
	logic [XLEN-1:0] ref_u;
	logic [XLEN-1:0] ref_j;

	assign ref_a = (issue_i.rs1_idx == ZERO_IDX) ? WORD_ZERO : issue_i.rs1_val;
	assign ref_b = (issue_i.rs2_idx == ZERO_IDX) ? WORD_ZERO : issue_i.rs2_val;
	assign ref_i = XLEN'($signed(issue_i.imm[IMM12_W-1:0]));
	assign ref_u = {issue_i.imm, WORD_ZERO[UPPER_LSB-1:0]};
	assign ref_j = XLEN'($signed({issue_i.imm, 1'b0}));

	chk_addi_sum: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_ADDI) |-> st.res.wr_data == $past(ref_a + ref_i))
		else $error("add immediate result wrong");

	chk_andi_mask: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_ANDI) |-> st.res.wr_data == $past(ref_a & ref_i))
		else $error("and immediate result wrong");

	chk_ori_mask: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_ORI) |-> st.res.wr_data == $past(ref_a | ref_i))
		else $error("or immediate result wrong");

	chk_xori_mask: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_XORI) |-> st.res.wr_data == $past(ref_a ^ ref_i))
		else $error("xor immediate result wrong");

	chk_slti_signed: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_SLTI) |->
		st.res.wr_data == ($past($signed(ref_a) < $signed(ref_i)) ? WORD_ONE : WORD_ZERO))
		else $error("signed immediate compare wrong");

	chk_sltiu_unsigned: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_SLTIU) |->
		st.res.wr_data == ($past(ref_a < ref_i) ? WORD_ONE : WORD_ZERO))
		else $error("unsigned immediate compare wrong");

	chk_slli_fill: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_SLLI) |->
		st.res.wr_data == $past(ref_a << issue_i.imm[SHAMT_W-1:0]))
		else $error("left immediate shift wrong");

	chk_srli_fill: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_SRLI) |->
		st.res.wr_data == $past(ref_a >> issue_i.imm[SHAMT_W-1:0]))
		else $error("logical right immediate shift wrong");

	chk_srai_fill: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_SRAI) |->
		st.res.wr_data == $past($signed(ref_a) >>> issue_i.imm[SHAMT_W-1:0]))
		else $error("arithmetic right immediate shift wrong");

	chk_auipc_sum: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_AUIPC) |-> st.res.wr_data == $past(issue_i.pc + ref_u))
		else $error("upper immediate to pc wrong");

	chk_add_wrap: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_ADD) |-> st.res.wr_data == $past(ref_a + ref_b))
		else $error("register add wrong");

	chk_and_bits: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_AND) |-> st.res.wr_data == $past(ref_a & ref_b))
		else $error("register and wrong");

	chk_or_bits: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_OR) |-> st.res.wr_data == $past(ref_a | ref_b))
		else $error("register or wrong");

	chk_xor_bits: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_XOR) |-> st.res.wr_data == $past(ref_a ^ ref_b))
		else $error("register xor wrong");

	chk_slt_signed: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_SLT) |->
		st.res.wr_data == ($past($signed(ref_a) < $signed(ref_b)) ? WORD_ONE : WORD_ZERO))
		else $error("signed register compare wrong");

	chk_sltu_unsigned: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_SLTU) |->
		st.res.wr_data == ($past(ref_a < ref_b) ? WORD_ONE : WORD_ZERO))
		else $error("unsigned register compare wrong");

	chk_sll_amount: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_SLL) |->
		st.res.wr_data == $past(ref_a << ref_b[SHAMT_W-1:0]))
		else $error("register left shift wrong");

	chk_srl_amount: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_SRL) |->
		st.res.wr_data == $past(ref_a >> ref_b[SHAMT_W-1:0]))
		else $error("register logical right shift wrong");

	chk_sra_amount: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_SRA) |->
		st.res.wr_data == $past($signed(ref_a) >>> ref_b[SHAMT_W-1:0]))
		else $error("register arithmetic right shift wrong");

	chk_jal_target: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_JAL) |-> st.res.target == $past(issue_i.pc + ref_j))
		else $error("jump target wrong");

	chk_jalr_target: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_JALR) |->
		st.res.target == $past((ref_a + ref_i) & LSB_CLEAR))
		else $error("register jump target wrong");

	chk_next_target: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && !st.res.misaligned |-> st.res.next_pc == st.res.target)
		else $error("next pc differs from target");

	chk_fault_hold: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.misaligned |->
		(st.res.next_pc == $past(issue_i.pc)) && !st.res.wr_en && !st.res.jump)
		else $error("faulting jump not held");

	chk_idle_clear: assert property (@(posedge clk_i) disable iff (srst_i)
		!st.res.valid |-> !st.res.wr_en && !st.res.jump && !st.res.misaligned &&
		(st.res.wr_data == WORD_ZERO) && (st.res.next_pc == WORD_ZERO))
		else $error("idle result not cleared");

	chk_zero_read: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && (st.op == OP_SUB) && ($past(issue_i.rs1_idx) == ZERO_IDX) |->
		st.res.wr_data == WORD_ZERO - $past(ref_b))
		else $error("index zero not read as zero");

	chk_write_enable: assert property (@(posedge clk_i) disable iff (srst_i)
		st.res.valid && !st.res.misaligned && (st.res.rd_idx != ZERO_IDX) |-> st.res.wr_en)
		else $error("result write dropped");

endmodule

// ### design/rv32i_exec_pkg.sv
// Purpose: Shared types and constants for the RV32I integer execute datapath
// Assumes: Decode hands over one decoded instruction per cycle at most
// Notes: Operation codes are internal and carry no meaning outside this block

package rv32i_exec_pkg;

	// ----------------------------------------------------------------
	// Widths and fixed values
	// ----------------------------------------------------------------
	localparam int XLEN = 32;
	localparam int IDX_W = 5;
	localparam int SHAMT_W = 5;
	localparam int IMM_W = 20;
	localparam int IMM12_W = 12;
	localparam int UPPER_LSB = 12;
	localparam logic [IDX_W-1:0] ZERO_IDX = 5'h00;
	localparam logic [XLEN-1:0] FULL_STEP = 32'h0000_0004;
	localparam logic [XLEN-1:0] HALF_STEP = 32'h0000_0002;
	localparam logic [XLEN-1:0] LSB_CLEAR = 32'hFFFF_FFFE;
	localparam logic [XLEN-1:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [XLEN-1:0] WORD_ONE = 32'h0000_0001;

	// ----------------------------------------------------------------
	// Operations
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_ADDI = 5'h00,
		OP_ANDI = 5'h01,
		OP_ORI = 5'h02,
		OP_XORI = 5'h03,
		OP_SLTI = 5'h04,
		OP_SLTIU = 5'h05,
		OP_SLLI = 5'h06,
		OP_SRLI = 5'h07,
		OP_SRAI = 5'h08,
		OP_LUI = 5'h09,
		OP_AUIPC = 5'h0A,
		OP_ADD = 5'h0B,
		OP_SUB = 5'h0C,
		OP_AND = 5'h0D,
		OP_OR = 5'h0E,
		OP_XOR = 5'h0F,
		OP_SLT = 5'h10,
		OP_SLTU = 5'h11,
		OP_SLL = 5'h12,
		OP_SRL = 5'h13,
		OP_SRA = 5'h14,
		OP_JAL = 5'h15,
		OP_JALR = 5'h16
	} alu_op_t;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		alu_op_t op;
		logic [IDX_W-1:0] rs1_idx;
		logic [IDX_W-1:0] rs2_idx;
		logic [IDX_W-1:0] rd_idx;
		logic [XLEN-1:0] rs1_val;
		logic [XLEN-1:0] rs2_val;
		logic [XLEN-1:0] pc;
		logic [IMM_W-1:0] imm;
		logic compressed;
	} issue_t;

	typedef struct packed {
		logic valid;
		logic wr_en;
		logic [IDX_W-1:0] rd_idx;
		logic [XLEN-1:0] wr_data;
		logic jump;
		logic [XLEN-1:0] target;
		logic misaligned;
		logic [XLEN-1:0] next_pc;
	} result_t;

	typedef struct packed {
		result_t res;
		alu_op_t op;
	} exec_state_t;

endpackage

// ### design/rv32i_shifter.sv
// Purpose: Log-depth barrel shifter for left, logical right and arithmetic right
// Assumes: Shift amount already limited to the low five bits
// Notes: Purely combinational

module rv32i_shifter
	import rv32i_exec_pkg::*;
#(
	parameter int WIDTH = XLEN,
	parameter int AMT_W = SHAMT_W
) (
	// Operand and control
	input wire logic [WIDTH-1:0] data_i,
	input wire logic [AMT_W-1:0] shamt_i,
	input wire logic right_i,
	input wire logic arith_i,
	// Result
	output logic [WIDTH-1:0] data_o
);

	logic [WIDTH-1:0] stage [AMT_W+1];
	logic fill;

	// Fill comes from the original sign, not a partly shifted stage
	assign fill = arith_i & right_i & data_i[WIDTH-1];
	assign stage[0] = data_i;

	for (genvar i = 0; i < AMT_W; i++) begin : g_stage
		localparam int S = 1 << i;
		logic [WIDTH-1:0] moved;
		// Vacated bits take zero unless arithmetic right
		assign moved = right_i ? {{S{fill}}, stage[i][WIDTH-1:S]} :
			{stage[i][WIDTH-1-S:0], {S{1'b0}}};
		assign stage[i+1] = shamt_i[i] ? moved : stage[i];
	end

	assign data_o = stage[AMT_W];

endmodule

// ### sim/rf_model.sv
// Purpose: Register file and issue side that feeds the execute block
// Assumes: Bench supplies decoded fields; this model adds the read data
// Notes: Index zero and idle operands show a toggling pattern, never a held value

module rf_model
	import rv32i_exec_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Decoded fields and retired results
	input wire issue_t req_i,
	input wire result_t res_i,
	// Issue bus to the block
	output issue_t issue_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [XLEN-1:0] regs [32];
	logic [XLEN-1:0] junk = 32'h5A5A_A5A5;

	always @(posedge clk_i) begin
		junk <= ~junk;
		if (res_i.valid && res_i.wr_en) begin
			regs[res_i.rd_idx] <= res_i.wr_data;
		end
	end

	// Zero index gets junk so the block must force zero itself
	always_comb begin
		issue_o = req_i;
		issue_o.rs1_val = (req_i.valid && req_i.rs1_idx != ZERO_IDX) ? regs[req_i.rs1_idx] : junk;
		issue_o.rs2_val = (req_i.valid && req_i.rs2_idx != ZERO_IDX) ? regs[req_i.rs2_idx] : ~junk;
	end
endmodule

// ### sim/tb.sv
// Purpose: Self-checking bench for the integer execute block
// Assumes: One result per issue, one cycle later
// Notes: Issues are spaced so register write-back lands before the next read, except the back-to-back pair in t_b2b

module tb
	import rv32i_exec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [XLEN-1:0] P = 32'h0000_0100;
	localparam logic [XLEN-1:0] N = 32'h0000_0104;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	issue_t req = '0;
	issue_t issue;
	result_t res;
	int failures = 0;
	int samples_checked = 0;

	rf_model rf (.clk_i(clk_i), .req_i(req), .res_i(res), .issue_o(issue));
	rv32i_integer_execute dut (.clk_i(clk_i), .srst_i(srst_i), .issue_i(issue), .result_o(res));

	initial begin
		forever #50 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic put(alu_op_t op, logic [4:0] d, a, b, logic [19:0] imm, logic [31:0] pc,
		logic comp);
		req = '{1'b1, op, a, b, d, WORD_ZERO, WORD_ZERO, pc, imm, comp};
	endtask

	task automatic look(logic [4:0] d, logic [31:0] exp, np, logic jmp, ok);
		chk(32'({res.valid, res.wr_en, res.jump, res.misaligned, res.rd_idx}),
			32'({1'b1, ok && d != ZERO_IDX, jmp && ok, !ok, d}));
		if (ok && d != ZERO_IDX) chk(res.wr_data, exp);
		chk(res.next_pc, np);
		if (ok) chk(res.target, np);
	endtask

	task automatic ex(alu_op_t op, logic [4:0] d, a, b, logic [19:0] imm, logic [31:0] pc,
		logic comp, logic [31:0] exp, np, logic ok = 1'b1);
		@(negedge clk_i);
		put(op, d, a, b, imm, pc, comp);
		@(negedge clk_i);
		req.valid = 1'b0;
		look(d, exp, np, op == OP_JAL || op == OP_JALR, ok);
		@(posedge clk_i);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_imm();
		ex(OP_ADDI, 5, 1, 0, 20'hAB800, P, 0, 32'h7FFF_F801, N);
		ex(OP_ADDI, 0, 1, 0, 20'h00001, P, 0, 32'h8000_0002, N);
		ex(OP_ANDI, 5, 1, 0, 20'h00F0F, P, 0, 32'h8000_0001, N);
		ex(OP_ORI, 5, 1, 0, 20'h000F0, P, 0, 32'h8000_00F1, N);
		ex(OP_XORI, 5, 1, 0, 20'h00FFF, P, 0, 32'h7FFF_FFFE, N);
		ex(OP_SLTI, 5, 1, 0, 20'h00FFF, P, 0, WORD_ONE, N);
		ex(OP_SLTI, 5, 3, 0, 20'h00001, P, 0, WORD_ZERO, N);
		ex(OP_SLTIU, 5, 1, 0, 20'h00FFF, P, 0, WORD_ONE, N);
		ex(OP_SLTIU, 5, 3, 0, 20'h00001, P, 0, WORD_ZERO, N);
	endtask

	task automatic t_shift();
		ex(OP_SLLI, 5, 1, 0, 20'hFFFE1, P, 0, 32'h0000_0002, N);
		ex(OP_SRLI, 5, 1, 0, 20'h00004, P, 0, 32'h0800_0000, N);
		ex(OP_SRAI, 5, 1, 0, 20'h00004, P, 0, 32'hF800_0000, N);
		ex(OP_SRAI, 5, 3, 0, 20'h0001F, P, 0, WORD_ZERO, N);
		ex(OP_SLL, 5, 3, 2, 20'h00000, P, 0, 32'hFFFF_FFF0, N);
		ex(OP_SRL, 5, 1, 2, 20'h00000, P, 0, 32'h0800_0000, N);
		ex(OP_SRA, 5, 1, 2, 20'h00000, P, 0, 32'hF800_0000, N);
	endtask

	task automatic t_reg();
		ex(OP_ADD, 5, 1, 3, 20'h00000, P, 0, WORD_ZERO, N);
		ex(OP_SUB, 5, 0, 1, 20'h00000, P, 0, 32'h7FFF_FFFF, N);
		ex(OP_AND, 5, 1, 3, 20'h00000, P, 0, WORD_ONE, N);
		ex(OP_OR, 5, 1, 3, 20'h00000, P, 0, 32'hFFFF_FFFF, N);
		ex(OP_XOR, 5, 1, 3, 20'h00000, P, 0, 32'hFFFF_FFFE, N);
		ex(OP_SLT, 5, 1, 3, 20'h00000, P, 0, WORD_ONE, N);
		ex(OP_SLTU, 5, 1, 3, 20'h00000, P, 0, WORD_ZERO, N);
		// Unused code must retire as a plain zero result
		ex(alu_op_t'(5'h1F), 5, 1, 3, 20'h00000, P, 0, WORD_ZERO, N);
	endtask

	task automatic t_upper();
		ex(OP_LUI, 5, 0, 0, 20'hABCDE, P, 0, 32'hABCD_E000, N);
		ex(OP_AUIPC, 5, 0, 0, 20'h00002, 32'hFFFF_F000, 1, 32'h0000_1000, 32'hFFFF_F002);
	endtask

	task automatic t_jump();
		// Written links land in 6, 5 and 4 so later scenarios still see the seeded rs1
		ex(OP_JAL, 6, 0, 0, 20'h00008, P, 0, N, 32'h0000_0110);
		ex(OP_JAL, 6, 0, 0, 20'hFFFFE, 32'h0000_0202, 1, 32'h0000_0204, 32'h0000_01FE);
		ex(OP_JAL, 1, 0, 0, 20'h00008, 32'h0000_0101, 0, N, 32'h0000_0101, 1'b0);
		ex(OP_JALR, 5, 1, 0, 20'h00FFF, P, 0, N, 32'h8000_0000);
		ex(OP_JALR, 4, 4, 0, 20'h00002, P, 0, N, 32'h0000_1002);
		@(negedge clk_i);
		chk(rf.regs[4], N);
	endtask

	// Back to back issues; each result stands for one cycle only
	task automatic t_b2b();
		@(negedge clk_i);
		put(OP_ADD, 6, 1, 3, 20'h00000, 32'h0000_0300, 1);
		@(negedge clk_i);
		put(OP_SUB, 7, 3, 1, 20'h00000, 32'h0000_0400, 0);
		look(6, WORD_ZERO, 32'h0000_0302, 0, 1);
		@(negedge clk_i);
		req.valid = 1'b0;
		look(7, 32'hFFFF_FFFE, 32'h0000_0404, 0, 1);
		@(negedge clk_i);
		chk(32'({res.valid, res.wr_en}), WORD_ZERO);
		chk(res.wr_data | res.target | res.next_pc, WORD_ZERO);
	endtask

	// Reset in mid-run wipes an instruction taken at the same edge
	task automatic t_rst();
		@(negedge clk_i);
		put(OP_LUI, 5, 0, 0, 20'hFFFFF, P, 0);
		srst_i = 1'b1;
		@(negedge clk_i);
		req.valid = 1'b0;
		chk(32'({res.valid, res.wr_en}) | res.wr_data, WORD_ZERO);
		srst_i = 1'b0;
	endtask

	initial begin
		rf.regs[1] = 32'h8000_0001;
		rf.regs[2] = 32'hFFFF_FFE4;
		rf.regs[3] = 32'h7FFF_FFFF;
		rf.regs[4] = 32'h0000_1001;
		repeat (20) @(posedge clk_i);
		@(negedge clk_i);
		srst_i = 1'b0;
		t_imm();
		t_shift();
		t_reg();
		t_upper();
		t_jump();
		t_b2b();
		t_rst();
		summarize();
	end

	// Run needs about 90 cycles; this cuts a hang short
	initial begin
		repeat (2000) @(posedge clk_i);
		failures++;
		summarize();
	end
endmodule
